//--- pkg/ipm_pkg.sv
// Package of constants and types for the idle power manager
package ipm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned IDLE_TIMEOUT_S = 30;
	localparam int unsigned IDLE_MIN_S = 15;
	localparam int unsigned IDLE_MAX_S = 60;
	localparam longint unsigned IDLE_CYCLES = 64'(IDLE_TIMEOUT_S) * CLK_HZ;
	localparam int unsigned WAKE_US = 100;
	localparam int unsigned WAKE_CYCLES = (WAKE_US * (CLK_HZ / 1_000_000));
	localparam int unsigned PUMP_KHZ = 70;
	// Phase step period rounded down so phase clock exceeds the minimum
	localparam int unsigned PUMP_DIV = (CLK_HZ / (PUMP_KHZ * 1000)) - 1;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int unsigned NUM_DRV = 3;
	localparam int unsigned NUM_RCV = 5;
	localparam logic [3:0] PHASE_RST = 4'h1;

	// ------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		IPM_ACTIVE = 4'h1,
		IPM_STANDBY = 4'h2,
		IPM_WAKING = 4'h4,
		IPM_SHUTDOWN = 4'h8
	} ipm_mode_t;

endpackage

//--- pkg/ipm_pump_if.sv
// Interface between the mode controller and the pump sequencer
interface ipm_pump_if;
	logic run;
	logic rails_low;
	logic [3:0] phase;
	modport ctrl (output run, output rails_low, input phase);
	modport pump (input run, input rails_low, output phase);
endinterface

//--- rtl/ipm_pump_seq.sv
// Charge pump four phase sequencer with on-demand oscillator
module ipm_pump_seq
	import ipm_pkg::*;
#(
	parameter int unsigned DIV = PUMP_DIV
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	ipm_pump_if.pump pif
);
	initial begin
		if (DIV < 1 || DIV > 65535) begin
			$error("ipm_pump_seq: DIV out of range");
		end
	end

	logic [15:0] div_cnt;
	logic [15:0] next_div_cnt;
	logic [3:0] phase;
	logic [3:0] next_phase;

	// ------------------------------------------------------------
	// Oscillator and phase ring
	// ------------------------------------------------------------
	always_comb begin
		next_div_cnt = div_cnt;
		next_phase = phase;
		// oscillate only when rails need it
		if (!pif.run || !pif.rails_low) begin
			next_div_cnt = 16'h0000;
		end else if (div_cnt == 16'(DIV)) begin
			next_div_cnt = 16'h0000;
			// charge, neg transfer, charge, pos transfer
			next_phase = {phase[2:0], phase[3]};
		end else begin
			next_div_cnt = div_cnt + 16'h0001;
		end
		if (!pif.run) begin
			next_phase = PHASE_RST;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			div_cnt <= 16'h0000;
			phase <= PHASE_RST;
		end else begin
			div_cnt <= next_div_cnt;
			phase <= next_phase;
		end
	end

	assign pif.phase = phase;
endmodule

//--- rtl/ipm_ctrl.sv
// Idle power manager: activity watch, mode control, output enables
//
// Summary of operation
// - After 30 s with no input activity, stop pump, tristate drivers.
// - Idle timeout lies between 15 and 60 seconds; only the 60 s maximum is checked for an IDLE_CNT other than the default.
// - Any driver or receiver input transition in standby wakes the device.
// - Pump and drivers ready within about 100 us after waking.
// - Receivers stay enabled during idle standby.
// - Shutdown pin low forces drivers and receivers off.
// - Always-on receiver output stays active in every mode.
// - Line flag is one when any receiver sees line voltage.
// - Line flag operates in every mode, shutdown included.
// - Force-awake high with shutdown high blocks idle standby.
// - Force-awake low still wakes on driver input activity.
// - Pump cycles charge, negative transfer, charge, positive transfer.
// - Pump oscillator runs only when rails need topping up, or while waking.
// - Pump phase clock exceeds 70 kHz when running.
module ipm_ctrl
	import ipm_pkg::*;
#(
	parameter longint unsigned IDLE_CNT = IDLE_CYCLES,
	parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [NUM_DRV-1:0] driver_logic_in_i,
	input wire logic [NUM_RCV-1:0] receiver_line_in_i,
	input wire logic [NUM_RCV-1:0] line_level_valid_i,
	input wire logic force_awake_i,
	input wire logic shutdown_n_i,
	input wire logic rails_low_i,
	output logic [NUM_DRV-1:0] line_driver_out_o,
	output logic [NUM_DRV-1:0] line_driver_oe_o,
	output logic [NUM_RCV-1:0] receiver_logic_out_o,
	output logic [NUM_RCV-1:0] receiver_logic_oe_o,
	output logic always_on_receiver_out_o,
	output logic line_present_o,
	output logic pump_run_o,
	output logic drivers_ready_o,
	output logic [3:0] pump_phase_o
);
	localparam int unsigned NIN = NUM_DRV + 2 * NUM_RCV + 2;

	initial begin
		if (IDLE_CNT < 64'(IDLE_MIN_S) * CLK_HZ && IDLE_CNT == IDLE_CYCLES) begin
			$error("ipm_ctrl: idle timeout below minimum");
		end
		if (IDLE_CNT > 64'(IDLE_MAX_S) * CLK_HZ) begin
			$error("ipm_ctrl: idle timeout above maximum");
		end
		if (IDLE_CNT < 2 || WAKE_CNT < 1 || WAKE_CNT > 65535) begin
			$error("ipm_ctrl: counts out of range");
		end
	end

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] sync_a;
	logic [NIN-1:0] sync_b;
	logic [NIN-1:0] sync_c;

	assign raw_in = {force_awake_i, shutdown_n_i, line_level_valid_i,
		receiver_line_in_i, driver_logic_in_i};

	always_ff @(posedge sys_clk_i) begin
		sync_a <= raw_in;
		sync_b <= sync_a;
		sync_c <= sync_b;
	end

	logic [NUM_DRV-1:0] drv_s;
	logic [NUM_RCV-1:0] rcv_s;
	logic [NUM_RCV-1:0] lvl_s;
	logic awake_s;
	logic shdn_n_s;
	logic [NUM_DRV+NUM_RCV-1:0] edges;
	logic any_edge;

	assign drv_s = sync_b[NUM_DRV-1:0];
	assign rcv_s = sync_b[NUM_DRV+NUM_RCV-1:NUM_DRV];
	assign lvl_s = sync_b[NUM_DRV+2*NUM_RCV-1:NUM_DRV+NUM_RCV];
	assign shdn_n_s = sync_b[NIN-2];
	assign awake_s = sync_b[NIN-1];
	// transition on any driver or receiver input
	assign edges = sync_b[NUM_DRV+NUM_RCV-1:0] ^ sync_c[NUM_DRV+NUM_RCV-1:0];
	assign any_edge = |edges;

	// ------------------------------------------------------------
	// Mode state machine
	// ------------------------------------------------------------
	ipm_mode_t mode;
	ipm_mode_t next_mode;
	logic [63:0] idle_cnt;
	logic [63:0] next_idle_cnt;
	logic [15:0] wake_cnt;
	logic [15:0] next_wake_cnt;

	always_comb begin
		next_mode = mode;
		next_idle_cnt = idle_cnt;
		next_wake_cnt = wake_cnt;
		if (any_edge) begin
			next_idle_cnt = 64'h0;
		end else if (idle_cnt < IDLE_CNT) begin
			next_idle_cnt = idle_cnt + 64'h1;
		end
		case (mode)
			IPM_ACTIVE: begin
				// expire with no edge enters standby
				if (!awake_s && !any_edge && idle_cnt >= IDLE_CNT - 1) begin
					next_mode = IPM_STANDBY;
				end
			end
			IPM_STANDBY: begin
				// driver edges wake even without line
				if (any_edge || awake_s) begin
					next_mode = IPM_WAKING;
					next_wake_cnt = 16'h0;
				end
			end
			IPM_WAKING: begin
				// pump settle time before drivers enabled
				if (wake_cnt >= 16'(WAKE_CNT - 1)) begin
					next_mode = IPM_ACTIVE;
				end else begin
					next_wake_cnt = wake_cnt + 16'h1;
				end
			end
			IPM_SHUTDOWN: begin
				if (shdn_n_s) begin
					next_mode = IPM_WAKING;
					next_wake_cnt = 16'h0;
					next_idle_cnt = 64'h0;
				end
			end
			default: begin
				next_mode = IPM_WAKING;
				next_wake_cnt = 16'h0;
			end
		endcase
		if (!shdn_n_s) begin
			next_mode = IPM_SHUTDOWN;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode <= IPM_WAKING;
			idle_cnt <= 64'h0;
			wake_cnt <= 16'h0;
		end else begin
			mode <= next_mode;
			idle_cnt <= next_idle_cnt;
			wake_cnt <= next_wake_cnt;
		end
	end

	// ------------------------------------------------------------
	// Charge pump
	// ------------------------------------------------------------
	ipm_pump_if pif ();
	logic rails_a;
	logic rails_b;

	always_ff @(posedge sys_clk_i) begin
		rails_a <= rails_low_i;
		rails_b <= rails_a;
	end

	assign pif.run = (mode == IPM_ACTIVE) || (mode == IPM_WAKING);
	// Pump forced on while waking so rails come up
	assign pif.rails_low = rails_b || (mode == IPM_WAKING);

	ipm_pump_seq u_pump (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.pif(pif)
	);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	logic [NUM_DRV-1:0] next_drv_oe;
	logic [NUM_RCV-1:0] next_rcv_oe;

	always_comb begin
		next_drv_oe = {NUM_DRV{mode == IPM_ACTIVE}};
		next_rcv_oe = {NUM_RCV{mode != IPM_SHUTDOWN}};
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			line_driver_out_o <= {NUM_DRV{1'b1}};
			line_driver_oe_o <= '0;
			receiver_logic_out_o <= {NUM_RCV{1'b1}};
			receiver_logic_oe_o <= '0;
			always_on_receiver_out_o <= 1'b0;
			line_present_o <= 1'b0;
			pump_run_o <= 1'b0;
			drivers_ready_o <= 1'b0;
			pump_phase_o <= PHASE_RST;
		end else begin
			// Drivers and receivers invert
			line_driver_out_o <= ~drv_s;
			line_driver_oe_o <= next_drv_oe;
			receiver_logic_out_o <= ~rcv_s;
			receiver_logic_oe_o <= next_rcv_oe;
			always_on_receiver_out_o <= rcv_s[1];
			line_present_o <= |lvl_s;
			pump_run_o <= pif.run;
			drivers_ready_o <= (mode == IPM_ACTIVE);
			pump_phase_o <= pif.phase;
		end
	end
endmodule

//--- dv/ipm_assertions.sv
// Port checker for the idle power manager
module ipm_assertions
	import ipm_pkg::*;
#(
	parameter longint unsigned IDLE_CNT = IDLE_CYCLES,
	parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [NUM_DRV-1:0] driver_logic_in_i,
	input wire logic [NUM_RCV-1:0] receiver_line_in_i,
	input wire logic [NUM_RCV-1:0] line_level_valid_i,
	input wire logic force_awake_i,
	input wire logic shutdown_n_i,
	input wire logic [NUM_DRV-1:0] line_driver_oe_o,
	input wire logic [NUM_RCV-1:0] receiver_logic_oe_o,
	input wire logic always_on_receiver_out_o,
	input wire logic line_present_o,
	input wire logic pump_run_o,
	input wire logic drivers_ready_o,
	input wire logic [3:0] pump_phase_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAKE_LIM = WAKE_CNT + 8;
	logic [7:0] ins, prev;
	longint unsigned quiet, next_quiet;
	assign ins = {driver_logic_in_i, receiver_line_in_i};
	// Cycles since the last pin change
	always_comb begin
		next_quiet = (ins != prev) ? 64'h0 : quiet + 64'h1;
	end
	always_ff @(posedge sys_clk_i) begin
		prev <= ins;
		quiet <= rst_i ? 64'h0 : next_quiet;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	AST_SHUTDOWN_OFF: assert property (!shutdown_n_i [*5] |->
		line_driver_oe_o == '0 && receiver_logic_oe_o == '0)
		else $error("outputs enabled in shutdown");
	AST_ALWAYS_ON: assert property ($stable(receiver_line_in_i) [*6] |->
		always_on_receiver_out_o == receiver_line_in_i[1])
		else $error("always-on output wrong");
	AST_LINE_FLAG: assert property ($stable(line_level_valid_i) [*6] |->
		line_present_o == |line_level_valid_i)
		else $error("line flag wrong");
	AST_RCV_ON: assert property (shutdown_n_i [*6] |->
		receiver_logic_oe_o == '1)
		else $error("receivers off while not shut down");
	AST_FORCE_AWAKE: assert property ((force_awake_i && shutdown_n_i) [*5]
		##0 line_driver_oe_o[0] |=> line_driver_oe_o[0])
		else $error("standby while forced awake");
	AST_WAKE: assert property (!pump_run_o && shutdown_n_i &&
		$changed(driver_logic_in_i) |-> ##[1:WAKE_LIM] drivers_ready_o)
		else $error("wake too slow");
	AST_IDLE_MIN: assert property (shutdown_n_i [*8] ##0
		$fell(line_driver_oe_o[0]) |-> quiet >= IDLE_CNT)
		else $error("standby before idle timeout");
	AST_PUMP_ORDER: assert property (pump_run_o && $past(pump_run_o) &&
		$changed(pump_phase_o) |->
		pump_phase_o == {$past(pump_phase_o[2:0]), $past(pump_phase_o[3])})
		else $error("pump phase out of order");
endmodule

//--- dv/ipm_partner.sv
// Far side model: host logic pins and remote line
module ipm_partner (
	input wire logic sys_clk_i,
	input wire logic talk_i,
	input wire logic cable_i,
	output logic [2:0] drv_o,
	output logic [4:0] rcv_o,
	output logic [4:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 67819;
	logic [7:0] pins = 8'h00;
	logic [4:0] lvl = 5'h00;
	assign {drv_o, rcv_o} = pins;
	assign lvl_o = lvl;
	// Top driver bit toggles on every cycle with talk_i high
	always @(negedge sys_clk_i) begin
		lvl <= {5{cable_i}};
		if (talk_i) begin
			pins <= pins ^ (8'($random(seed)) | 8'h80);
		end
	end
endmodule

//--- dv/test_idle_power_manager.sv
// Self-checking bench for the idle power manager
`define CHK(nm, e, a) begin checks_done++; if ((e) !== (a)) begin \
	$display("CHECK FAILED %s exp %h got %h", nm, e, a); fail_count++; end end
module test_idle_power_manager;
	timeunit 1ns;
	timeprecision 1ps;
	import ipm_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, talk = 0, cable = 0, legacy = 0;
	logic force_awake = 0, shutdown_n = 1, rails_low = 1;
	logic [2:0] drv, drv_oe;
	logic [4:0] rcv, lvl, rcv_oe;
	logic ao, lp, rdy, run;
	logic [3:0] phase;
	logic fa_pin = 0, sd_pin = 1;
	logic [2:0] tx_out;
	logic [4:0] rx_out;
	logic [3:0] ph;
	int steps;
	logic [10:0] q[$], er;
	int fail_count = 0, checks_done = 0, n;
	event obs;
	always #2 sys_clk_i = ~sys_clk_i;
	ipm_ctrl #(.IDLE_CNT(200), .WAKE_CNT(10)) ipm_ctrl_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .driver_logic_in_i(drv),
		.receiver_line_in_i(rcv), .line_level_valid_i(lvl),
		.force_awake_i(fa_pin), .shutdown_n_i(sd_pin),
		.rails_low_i(rails_low), .line_driver_out_o(tx_out),
		.line_driver_oe_o(drv_oe), .receiver_logic_out_o(rx_out),
		.receiver_logic_oe_o(rcv_oe), .always_on_receiver_out_o(ao),
		.line_present_o(lp), .pump_run_o(run), .drivers_ready_o(rdy),
		.pump_phase_o(phase));
	ipm_partner ipm_partner_i (.sys_clk_i(sys_clk_i), .talk_i(talk),
		.cable_i(cable), .drv_o(drv), .rcv_o(rcv), .lvl_o(lvl));
	always @(negedge sys_clk_i) begin
		fa_pin <= legacy ? lp : force_awake;
		sd_pin <= legacy ? lp : shutdown_n;
	end
	always @(obs) begin
		#1;
		er = q.pop_front();
		`CHK("outputs", er, {drv_oe, rcv_oe, lp, ao, rdy})
		`CHK("driver_out", ~drv, tx_out)
		`CHK("receiver_out", ~rcv, rx_out)
	end
	task automatic note(input logic [10:0] e);
		q.push_back(e);
		-> obs;
		@(negedge sys_clk_i);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (drv_oe[0] !== v) begin
			@(negedge sys_clk_i);
			n++;
			if (n > lim) begin
				fail_count++;
				finish_test();
			end
		end
	endtask
	task automatic pulse();
		talk <= 1;
		@(negedge sys_clk_i);
		talk <= 0;
	endtask
	initial begin
		repeat (20) @(negedge sys_clk_i);
		rst_i <= 0;
		wait_oe(1, 40);
		note({3'h7, 5'h1f, 1'h0, rcv[1], 1'h1});
		repeat (3) begin
			repeat (150) @(negedge sys_clk_i);
			pulse();
			repeat (8) @(negedge sys_clk_i);
			note({3'h7, 5'h1f, 1'h0, rcv[1], 1'h1});
		end
		wait_oe(0, 300);
		`CHK("idle", 1'h1, 1'(n > 185 && n < 215))
		note({3'h0, 5'h1f, 1'h0, rcv[1], 1'h0});
		`CHK("pump_off", 1'h0, run)
		pulse();
		wait_oe(1, 22);
		note({3'h7, 5'h1f, 1'h0, rcv[1], 1'h1});
		force_awake <= 1;
		ph = phase;
		steps = 0;
		repeat (15000) begin
			@(negedge sys_clk_i);
			if (phase !== ph) begin
				`CHK("pump_phase", {ph[2:0], ph[3]}, phase)
				steps++;
				ph = phase;
			end
		end
		`CHK("pump_rate", 2'h3, {run, 1'(steps >= 4)})
		note({3'h7, 5'h1f, 1'h0, rcv[1], 1'h1});
		shutdown_n <= 0;
		cable <= 1;
		rails_low <= 0;
		pulse();
		repeat (10) @(negedge sys_clk_i);
		note({3'h0, 5'h0, 1'h1, rcv[1], 1'h0});
		`CHK("pump_off", 1'h0, run)
		legacy <= 1;
		wait_oe(1, 60);
		note({3'h7, 5'h1f, 1'h1, rcv[1], 1'h1});
		ph = phase;
		repeat (4000) @(negedge sys_clk_i);
		`CHK("pump_hold", {1'h1, ph}, {run, phase})
		cable <= 0;
		repeat (12) @(negedge sys_clk_i);
		note({3'h0, 5'h0, 1'h0, rcv[1], 1'h0});
		finish_test();
	end
endmodule
bind ipm_ctrl ipm_assertions #(.IDLE_CNT(IDLE_CNT), .WAKE_CNT(WAKE_CNT))
	ipm_assertions_i (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.driver_logic_in_i(driver_logic_in_i),
	.receiver_line_in_i(receiver_line_in_i),
	.line_level_valid_i(line_level_valid_i),
	.force_awake_i(force_awake_i),
	.shutdown_n_i(shutdown_n_i),
	.line_driver_oe_o(line_driver_oe_o),
	.receiver_logic_oe_o(receiver_logic_oe_o),
	.always_on_receiver_out_o(always_on_receiver_out_o),
	.line_present_o(line_present_o),
	.pump_run_o(pump_run_o),
	.drivers_ready_o(drivers_ready_o),
	.pump_phase_o(pump_phase_o)
);
